// ### rtl/beacon_service_pkg.sv
// Constants, encodings and register layout of the beacon service controller.
// Assumes a single 250 MHz clock shared with the MAC timing and beacon engines.
package beacon_service_pkg;

  // Clock and timing.
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned CYC_PER_US    = US_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  US_DIV_LAST   = 8'(CYC_PER_US - 1);
  localparam logic [15:0] OFFSET_MAX    = 16'hffff;

  // Widths.
  localparam int unsigned CHAN_W  = 8;
  localparam int unsigned LEVEL_W = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 8;

  // Outcome codes.
  localparam logic [1:0] OUT_SUCCESS  = 2'h0;
  localparam logic [1:0] OUT_FAILURE  = 2'h1;
  localparam logic [1:0] OUT_NO_SLOT  = 2'h2;

  // Beacon classes.
  localparam logic [1:0] CLASS_NEIGHBOUR = 2'h0;
  localparam logic [1:0] CLASS_ALIEN     = 2'h1;
  localparam logic [1:0] CLASS_OWN       = 2'h2;

  // Register offsets.
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] COUNT_OFF  = 8'h08;

  // Control register fields and reset values.
  localparam int unsigned CTRL_TIMEOUT_LSB = 0;
  localparam int unsigned CTRL_RX_EN_BIT   = 8;
  localparam logic [7:0]  TIMEOUT_RESET    = 8'h08;
  localparam logic        RX_EN_RESET      = 1'b1;

  // Status register field positions.
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_SW_LSB    = 2;
  localparam int unsigned STAT_CHAN_LSB  = 4;
  localparam int unsigned STAT_CNT_LSB   = 12;
  localparam int unsigned STAT_BEN_BIT   = 20;

  localparam logic [CHAN_W-1:0] CHAN_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_STARTING = 2'b01,
    ST_ACTIVE   = 2'b11,
    ST_STOPPING = 2'b10
  } beacon_state_e;

  typedef enum logic [1:0] {
    SW_IDLE   = 2'b00,
    SW_NOTICE = 2'b01,
    SW_VERIFY = 2'b11
  } switch_state_e;

endpackage

// ### rtl/beacon_service_control.sv
// Beacon start, stop and channel switch control with per-beacon reporting.
// Assumes the timing, beacon and receive engines run on clk and give one-cycle pulses.
//
// What this block does
// - Start request begins beacons on given channel.
// - Start confirmed after first beacon or failure.
// - Unsuccessful operations time out with failure.
// - Stop request ends beacon transmission immediately.
// - Stop success needs one silent beacon period.
// - Switch element sent in notice-count superframes.
// - Nonzero notice: switch after countdown-zero superframe.
// - Zero notice: switch at current superframe end.
// - Switched channel applies to all frames.
// - Switch success needs period with tx and rx.
// - Report every received and transmitted beacon.
// - Report carries contents, channel, offset, class, levels.
// - Active device reports own beacon each period.
// - Receive reports follow receiver enable, not scanning.
// - Offset is microseconds from period start, 16 bits.
// - Link quality and strength are 0 to 255.
// - Class is neighbour, alien or own.
// - Start/stop outcome: success, failure, no slot.
// - Offsets share the period start reference.
`timescale 1ns/1ns
module beacon_service_control (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Requests from the management host.
  input  wire logic        beacon_begin_cmd,
  input  wire logic [7:0]  begin_channel,
  input  wire logic        beacon_end_cmd,
  input  wire logic        channel_switch_cmd,
  input  wire logic [7:0]  switch_channel,
  input  wire logic [7:0]  switch_notice_count,
  // Confirmations to the management host.
  output logic             begin_done,
  output logic      [1:0]  begin_outcome_code,
  output logic             end_done,
  output logic      [1:0]  end_outcome_code,
  output logic             switch_done,
  output logic      [1:0]  switch_outcome_code,
  // MAC timing and beacon engine.
  input  wire logic        period_start,
  input  wire logic        period_end,
  input  wire logic        superframe_end,
  input  wire logic        own_beacon_sent,
  input  wire logic [31:0] tx_contents,
  input  wire logic        slot_refused,
  output logic             beacon_enable,
  output logic      [7:0]  phy_channel,
  output logic             switch_element_en,
  output logic      [7:0]  switch_countdown,
  // Receive engine.
  input  wire logic        beacon_rx,
  input  wire logic [1:0]  rx_class,
  input  wire logic [31:0] rx_contents,
  input  wire logic [7:0]  rx_link_quality,
  input  wire logic [7:0]  rx_signal_strength,
  output logic             rx_enable,
  // Beacon reports.
  output logic             beacon_report,
  output logic      [1:0]  report_class,
  output logic      [7:0]  report_channel,
  output logic      [15:0] report_offset,
  output logic      [7:0]  report_link_quality,
  output logic      [7:0]  report_signal_strength,
  output logic      [31:0] report_contents
);

  typedef struct packed {
    beacon_service_pkg::beacon_state_e st;
    beacon_service_pkg::switch_state_e sw;
    logic        beacon_en;
    logic [7:0]  chan;
    logic [7:0]  new_chan;
    logic [7:0]  countdown;
    logic        sw_elem;
    logic [7:0]  timer;
    logic        armed;
    logic        saw_tx;
    logic        saw_rx;
    logic        begin_done;
    logic [1:0]  begin_out;
    logic        end_done;
    logic [1:0]  end_out;
    logic        sw_done;
    logic [1:0]  sw_out;
    logic        rep_valid;
    logic [1:0]  rep_class;
    logic [7:0]  rep_chan;
    logic [15:0] rep_off;
    logic [7:0]  rep_lq;
    logic [7:0]  rep_ss;
    logic [31:0] rep_contents;
    logic        pend_valid;
    logic [1:0]  pend_class;
    logic [15:0] pend_off;
    logic [7:0]  pend_lq;
    logic [7:0]  pend_ss;
    logic [31:0] pend_contents;
    logic [7:0]  us_div;
    logic [15:0] offset;
    logic [7:0]  timeout_cfg;
    logic        rx_en;
    logic [31:0] rep_count;
    logic [31:0] rdata;
  } state_s;

  state_s s_q;
  state_s s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.begin_done = 1'b0;
    s_d.end_done   = 1'b0;
    s_d.sw_done    = 1'b0;
    s_d.rep_valid  = 1'b0;
    s_d.rdata      = 32'h0;

    // Microsecond offset from the own period start, saturating at the field limit.
    if (period_start)
    begin
      s_d.us_div = 8'h00;
      s_d.offset = 16'h0000;
    end
    else if (s_q.us_div == beacon_service_pkg::US_DIV_LAST)
    begin
      s_d.us_div = 8'h00;
      if (s_q.offset != beacon_service_pkg::OFFSET_MAX)
      begin
        s_d.offset = s_q.offset + 16'h0001;
      end
    end
    else
    begin
      s_d.us_div = s_q.us_div + 8'h01;
    end

    // Operation timeout counts beacon period ends seen while waiting.
    if (period_end && s_q.timer != 8'hff)
    begin
      s_d.timer = s_q.timer + 8'h01;
    end

    // Beacon period observation window used by stop and switch checks.
    if (period_start)
    begin
      s_d.armed  = 1'b1;
      s_d.saw_tx = 1'b0;
      s_d.saw_rx = 1'b0;
    end
    if (own_beacon_sent)
    begin
      s_d.saw_tx = 1'b1;
    end
    if (beacon_rx && s_q.rx_en)
    begin
      s_d.saw_rx = 1'b1;
    end

    case (s_q.st)
      beacon_service_pkg::ST_IDLE:
      begin
        if (beacon_begin_cmd)
        begin
          s_d.st        = beacon_service_pkg::ST_STARTING;
          s_d.beacon_en = 1'b1;
          s_d.chan      = begin_channel;
          s_d.timer     = 8'h00;
        end
      end
      beacon_service_pkg::ST_STARTING:
      begin
        if (own_beacon_sent)
        begin
          s_d.st         = beacon_service_pkg::ST_ACTIVE;
          s_d.begin_done = 1'b1;
          s_d.begin_out  = beacon_service_pkg::OUT_SUCCESS;
        end
        else if (slot_refused)
        begin
          s_d.st         = beacon_service_pkg::ST_IDLE;
          s_d.beacon_en  = 1'b0;
          s_d.begin_done = 1'b1;
          s_d.begin_out  = beacon_service_pkg::OUT_NO_SLOT;
        end
        else if (s_q.timer >= s_q.timeout_cfg)
        begin
          s_d.st         = beacon_service_pkg::ST_IDLE;
          s_d.beacon_en  = 1'b0;
          s_d.begin_done = 1'b1;
          s_d.begin_out  = beacon_service_pkg::OUT_FAILURE;
        end
      end
      beacon_service_pkg::ST_ACTIVE:
      begin
        if (beacon_end_cmd)
        begin
          // A pending switch cannot complete once beacons stop, so it fails here.
          s_d.st        = beacon_service_pkg::ST_STOPPING;
          s_d.beacon_en = 1'b0;
          s_d.armed     = 1'b0;
          s_d.timer     = 8'h00;
          if (s_q.sw != beacon_service_pkg::SW_IDLE)
          begin
            s_d.sw      = beacon_service_pkg::SW_IDLE;
            s_d.sw_elem = 1'b0;
            s_d.sw_done = 1'b1;
            s_d.sw_out  = beacon_service_pkg::OUT_FAILURE;
          end
        end
      end
      beacon_service_pkg::ST_STOPPING:
      begin
        if (period_end && s_q.armed && !s_q.saw_tx && !own_beacon_sent)
        begin
          s_d.st       = beacon_service_pkg::ST_IDLE;
          s_d.end_done = 1'b1;
          s_d.end_out  = beacon_service_pkg::OUT_SUCCESS;
        end
        else if (s_q.timer >= s_q.timeout_cfg)
        begin
          // The engine kept sending; beaconing is switched back on, as the host saw it.
          s_d.st        = beacon_service_pkg::ST_ACTIVE;
          s_d.beacon_en = 1'b1;
          s_d.end_done  = 1'b1;
          s_d.end_out   = beacon_service_pkg::OUT_FAILURE;
        end
      end
      default:
      begin
        s_d.st = beacon_service_pkg::ST_IDLE;
      end
    endcase

    // Start and stop requests that arrive in the wrong state are refused at once.
    if (beacon_begin_cmd && s_q.st != beacon_service_pkg::ST_IDLE)
    begin
      s_d.begin_done = 1'b1;
      s_d.begin_out  = beacon_service_pkg::OUT_FAILURE;
    end
    if (beacon_end_cmd && s_q.st != beacon_service_pkg::ST_ACTIVE)
    begin
      s_d.end_done = 1'b1;
      s_d.end_out  = beacon_service_pkg::OUT_FAILURE;
    end

    case (s_q.sw)
      beacon_service_pkg::SW_IDLE:
      begin
        if (channel_switch_cmd)
        begin
          if (s_q.st == beacon_service_pkg::ST_ACTIVE && !beacon_end_cmd)
          begin
            s_d.sw       = beacon_service_pkg::SW_NOTICE;
            s_d.new_chan = switch_channel;
            s_d.timer    = 8'h00;
            s_d.sw_elem  = (switch_notice_count != 8'h00);
            s_d.countdown = (switch_notice_count != 8'h00) ? switch_notice_count - 8'h01 : 8'h00;
          end
          else
          begin
            s_d.sw_done = 1'b1;
            s_d.sw_out  = beacon_service_pkg::OUT_FAILURE;
          end
        end
      end
      beacon_service_pkg::SW_NOTICE:
      begin
        if (superframe_end)
        begin
          if (s_q.countdown == 8'h00)
          begin
            // One channel feeds tx and rx alike, so every frame follows the switch.
            s_d.chan    = s_q.new_chan;
            s_d.sw_elem = 1'b0;
            s_d.sw      = beacon_service_pkg::SW_VERIFY;
            s_d.armed   = 1'b0;
            s_d.timer   = 8'h00;
          end
          else
          begin
            s_d.countdown = s_q.countdown - 8'h01;
          end
        end
      end
      beacon_service_pkg::SW_VERIFY:
      begin
        if (period_end && s_q.armed && (s_q.saw_tx || own_beacon_sent) && (s_q.saw_rx || (beacon_rx && s_q.rx_en)))
        begin
          s_d.sw      = beacon_service_pkg::SW_IDLE;
          s_d.sw_done = 1'b1;
          s_d.sw_out  = beacon_service_pkg::OUT_SUCCESS;
        end
        else if (s_q.timer >= s_q.timeout_cfg)
        begin
          s_d.sw      = beacon_service_pkg::SW_IDLE;
          s_d.sw_done = 1'b1;
          s_d.sw_out  = beacon_service_pkg::OUT_FAILURE;
        end
      end
      default:
      begin
        s_d.sw = beacon_service_pkg::SW_IDLE;
      end
    endcase
    if (s_q.sw != beacon_service_pkg::SW_IDLE && s_q.st != beacon_service_pkg::ST_ACTIVE)
    begin
      s_d.sw      = beacon_service_pkg::SW_IDLE;
      s_d.sw_elem = 1'b0;
    end

    // Own beacons win the report slot; a receive in the same cycle waits one cycle.
    if (own_beacon_sent)
    begin
      s_d.rep_valid    = 1'b1;
      s_d.rep_class    = beacon_service_pkg::CLASS_OWN;
      s_d.rep_chan     = s_q.chan;
      s_d.rep_off      = s_q.offset;
      s_d.rep_lq       = 8'h00;
      s_d.rep_ss       = 8'h00;
      s_d.rep_contents = tx_contents;
      if (beacon_rx && s_q.rx_en)
      begin
        s_d.pend_valid    = 1'b1;
        s_d.pend_class    = (rx_class == beacon_service_pkg::CLASS_ALIEN) ?
                            beacon_service_pkg::CLASS_ALIEN : beacon_service_pkg::CLASS_NEIGHBOUR;
        s_d.pend_off      = s_q.offset;
        s_d.pend_lq       = rx_link_quality;
        s_d.pend_ss       = rx_signal_strength;
        s_d.pend_contents = rx_contents;
      end
    end
    else if (beacon_rx && s_q.rx_en)
    begin
      s_d.rep_valid    = 1'b1;
      s_d.rep_class    = (rx_class == beacon_service_pkg::CLASS_ALIEN) ?
                         beacon_service_pkg::CLASS_ALIEN : beacon_service_pkg::CLASS_NEIGHBOUR;
      s_d.rep_chan     = s_q.chan;
      s_d.rep_off      = s_q.offset;
      s_d.rep_lq       = rx_link_quality;
      s_d.rep_ss       = rx_signal_strength;
      s_d.rep_contents = rx_contents;
    end
    else if (s_q.pend_valid)
    begin
      s_d.pend_valid   = 1'b0;
      s_d.rep_valid    = 1'b1;
      s_d.rep_class    = s_q.pend_class;
      s_d.rep_chan     = s_q.chan;
      s_d.rep_off      = s_q.pend_off;
      s_d.rep_lq       = s_q.pend_lq;
      s_d.rep_ss       = s_q.pend_ss;
      s_d.rep_contents = s_q.pend_contents;
    end
    if (s_d.rep_valid)
    begin
      s_d.rep_count = s_q.rep_count + 32'h1;
    end

    // Register port; unmapped reads return zero and unmapped writes are dropped.
    if (reg_wr && reg_addr == beacon_service_pkg::CTRL_OFF)
    begin
      s_d.timeout_cfg = reg_wdata[beacon_service_pkg::CTRL_TIMEOUT_LSB +: 8];
      s_d.rx_en       = reg_wdata[beacon_service_pkg::CTRL_RX_EN_BIT];
    end
    if (reg_rd)
    begin
      case (reg_addr)
        beacon_service_pkg::CTRL_OFF:
        begin
          s_d.rdata[beacon_service_pkg::CTRL_TIMEOUT_LSB +: 8] = s_q.timeout_cfg;
          s_d.rdata[beacon_service_pkg::CTRL_RX_EN_BIT]        = s_q.rx_en;
        end
        beacon_service_pkg::STATUS_OFF:
        begin
          s_d.rdata[beacon_service_pkg::STAT_STATE_LSB +: 2] = s_q.st;
          s_d.rdata[beacon_service_pkg::STAT_SW_LSB +: 2]    = s_q.sw;
          s_d.rdata[beacon_service_pkg::STAT_CHAN_LSB +: 8]  = s_q.chan;
          s_d.rdata[beacon_service_pkg::STAT_CNT_LSB +: 8]   = s_q.countdown;
          s_d.rdata[beacon_service_pkg::STAT_BEN_BIT]        = s_q.beacon_en;
        end
        beacon_service_pkg::COUNT_OFF:
        begin
          s_d.rdata = s_q.rep_count;
        end
        default:
        begin
          s_d.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q             <= '0;
      s_q.st          <= beacon_service_pkg::ST_IDLE;
      s_q.sw          <= beacon_service_pkg::SW_IDLE;
      s_q.chan        <= beacon_service_pkg::CHAN_RESET;
      s_q.timeout_cfg <= beacon_service_pkg::TIMEOUT_RESET;
      s_q.rx_en       <= beacon_service_pkg::RX_EN_RESET;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata              = s_q.rdata;
  assign begin_done             = s_q.begin_done;
  assign begin_outcome_code     = s_q.begin_out;
  assign end_done               = s_q.end_done;
  assign end_outcome_code       = s_q.end_out;
  assign switch_done            = s_q.sw_done;
  assign switch_outcome_code    = s_q.sw_out;
  assign beacon_enable          = s_q.beacon_en;
  assign phy_channel            = s_q.chan;
  assign switch_element_en      = s_q.sw_elem;
  assign switch_countdown       = s_q.countdown;
  assign rx_enable              = s_q.rx_en;
  assign beacon_report          = s_q.rep_valid;
  assign report_class           = s_q.rep_class;
  assign report_channel         = s_q.rep_chan;
  assign report_offset          = s_q.rep_off;
  assign report_link_quality    = s_q.rep_lq;
  assign report_signal_strength = s_q.rep_ss;
  assign report_contents        = s_q.rep_contents;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_begin_enables: assert property (beacon_begin_cmd && clk_en && s_q.st == beacon_service_pkg::ST_IDLE
    |=> beacon_enable && phy_channel == $past(begin_channel)) else $error("start did not enable beacons");
  a_begin_ok_cause: assert property ($rose(begin_done) && begin_outcome_code == beacon_service_pkg::OUT_SUCCESS
    |-> $past(own_beacon_sent && s_q.st == beacon_service_pkg::ST_STARTING)) else $error("early start confirm");
  a_stop_immediate: assert property (beacon_end_cmd && clk_en && s_q.st == beacon_service_pkg::ST_ACTIVE
    |=> !beacon_enable) else $error("stop did not end beacons");
  a_stop_quiet_period: assert property ($rose(end_done) && end_outcome_code == beacon_service_pkg::OUT_SUCCESS
    |-> $past(period_end && s_q.armed && !s_q.saw_tx && !beacon_enable)) else $error("stop confirmed too early");
  a_notice_element: assert property (s_q.sw == beacon_service_pkg::SW_NOTICE && s_q.countdown != 8'h00
    |-> switch_element_en) else $error("switch element missing");
  a_switch_moment: assert property ($changed(phy_channel) && $past(s_q.st) != beacon_service_pkg::ST_IDLE
    |-> $past(superframe_end && s_q.countdown == 8'h00)) else $error("channel moved off boundary");
  a_switch_ok_cause: assert property ($rose(switch_done) && switch_outcome_code == beacon_service_pkg::OUT_SUCCESS
    |-> $past(period_end && s_q.armed && s_q.sw == beacon_service_pkg::SW_VERIFY)) else $error("early switch confirm");
  a_own_reported: assert property (own_beacon_sent && clk_en
    |=> beacon_report && report_class == beacon_service_pkg::CLASS_OWN) else $error("own beacon not reported");
  a_rx_reported: assert property (beacon_rx && rx_enable && !own_beacon_sent && clk_en
    |=> beacon_report && report_class != beacon_service_pkg::CLASS_OWN
        && report_link_quality == $past(rx_link_quality)) else $error("receive report wrong");

endmodule

// ### verif/mac_engine_model.sv
// Behavioural MAC timing, beacon and receive engine facing the controller.
// Assumes it shares clk and reset_n with the controller; one superframe is PERIOD cycles.
`timescale 1ns/1ns
module mac_engine_model #(
  parameter int PERIOD = 600
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic beacon_enable,
  input  wire logic send_ok,
  input  wire logic rx_on,
  output logic      period_start,
  output logic      period_end,
  output logic      superframe_end,
  output logic      own_beacon_sent,
  output logic      beacon_rx
);
  int cnt;

  // The received beacon lands late in the period so that its reported offset is 2 microseconds.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt             <= 0;
      period_start    <= 1'b0;
      period_end      <= 1'b0;
      superframe_end  <= 1'b0;
      own_beacon_sent <= 1'b0;
      beacon_rx       <= 1'b0;
    end
    else
    begin
      cnt             <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      period_start    <= (cnt == 0);
      own_beacon_sent <= (cnt == 4) && beacon_enable && send_ok;
      beacon_rx       <= (cnt == 520) && rx_on;
      period_end      <= (cnt == PERIOD - 2);
      superframe_end  <= (cnt == PERIOD - 1);
    end
  end
endmodule

// ### verif/tb_beacon_service_control.sv
// Self-checking bench for the beacon service controller; the bench plays the host.
// Assumes the engine model supplies period timing, own beacons and received beacons.
`timescale 1ns/1ns
module tb_beacon_service_control;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, slot_refused = 1'b0, send_ok = 1'b0, rx_on = 1'b1;
  logic [2:0]  cmd = 3'h0;
  logic [7:0]  reg_addr = 8'h00, chan = 8'h00, notice = 8'h00, phy, cdown, lq, ss, rchan;
  logic [31:0] reg_wdata = 32'h0, rdata, rcont;
  logic [1:0]  rx_class = 2'h1, bcode, ecode, scode, rcls;
  logic [15:0] roff;
  logic        pstart, pend, sfend, sent, brx, ben, elem, rxen, rep, bdone, edone, sdone;
  logic [4:0]  ev;
  int          failures = 0, compares = 0;

  assign ev = {rep === 1'b1 && rcls !== beacon_service_pkg::CLASS_OWN, bdone, edone, sdone, sfend};

  always #2 clk = ~clk;

  mac_engine_model mac_engine_model_inst (.clk(clk), .reset_n(reset_n), .beacon_enable(ben), .send_ok(send_ok),
    .rx_on(rx_on), .period_start(pstart), .period_end(pend), .superframe_end(sfend), .own_beacon_sent(sent),
    .beacon_rx(brx));

  beacon_service_control beacon_service_control_inst (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .beacon_begin_cmd(cmd[0]), .begin_channel(chan), .beacon_end_cmd(cmd[1]), .channel_switch_cmd(cmd[2]),
    .switch_channel(chan), .switch_notice_count(notice), .begin_done(bdone), .begin_outcome_code(bcode),
    .end_done(edone), .end_outcome_code(ecode), .switch_done(sdone), .switch_outcome_code(scode),
    .period_start(pstart), .period_end(pend), .superframe_end(sfend), .own_beacon_sent(sent),
    .tx_contents(32'h0000_beef), .slot_refused(slot_refused), .beacon_enable(ben), .phy_channel(phy),
    .switch_element_en(elem), .switch_countdown(cdown), .beacon_rx(brx), .rx_class(rx_class),
    .rx_contents(32'h0000_1234), .rx_link_quality(8'h5a), .rx_signal_strength(8'ha5), .rx_enable(rxen),
    .beacon_report(rep), .report_class(rcls), .report_channel(rchan), .report_offset(roff),
    .report_link_quality(lq), .report_signal_strength(ss), .report_contents(rcont));

  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Read data stand only in the cycle after the read edge, so they are sampled just after it.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= wr;
    reg_rd    <= !wr;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask

  task automatic go(input int k, input logic [7:0] c, input logic [7:0] n);
    @(posedge clk);
    cmd    <= 3'(1 << k);
    chan   <= c;
    notice <= n;
    @(posedge clk);
    cmd <= 3'h0;
  endtask

  task automatic wait_ev(input int k);
    for (int i = 0; i < 5000; i++)
    begin
      #1;
      if (ev[k] === 1'b1)
        return;
      @(posedge clk);
    end
    chk("wait", 1, 0);
  endtask

  initial
  begin
    #160000;
    failures++;
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("rx_enable", 1, rxen);
    chk("phy_channel", 0, phy);
    bus(0, beacon_service_pkg::CTRL_OFF, 0);
    chk("ctrl", 32'h108, rdata);
    bus(0, 8'h0c, 0);
    chk("unmapped", 0, rdata);
    bus(1, beacon_service_pkg::CTRL_OFF, 32'h102);
    go(1, 0, 0);
    wait_ev(2);
    chk("idle_stop", beacon_service_pkg::OUT_FAILURE, ecode);
    go(0, 5, 0);
    wait_ev(3);
    chk("start_timeout", beacon_service_pkg::OUT_FAILURE, bcode);
    go(0, 5, 0);
    @(posedge clk);
    slot_refused <= 1'b1;
    @(posedge clk);
    slot_refused <= 1'b0;
    wait_ev(3);
    chk("start_no_slot", beacon_service_pkg::OUT_NO_SLOT, bcode);
    send_ok <= 1'b1;
    go(0, 5, 0);
    #1;
    chk("beacon_enable", 1, ben);
    chk("start_channel", 5, phy);
    wait_ev(3);
    chk("start_code", beacon_service_pkg::OUT_SUCCESS, bcode);
    chk("own_report", 1, rep);
    chk("own_class", beacon_service_pkg::CLASS_OWN, rcls);
    chk("own_contents", 32'h0000_beef, rcont);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      rx_class <= 2'(k);
      wait_ev(4);
      chk("rx_class", 2'(k), rcls);
      chk("rx_offset", 2, roff);
      chk("rx_channel", 5, rchan);
      chk("rx_quality", 8'h5a, lq);
      chk("rx_strength", 8'ha5, ss);
      chk("rx_contents", 32'h0000_1234, rcont);
    end
    go(2, 7, 0);
    wait_ev(0);
    @(posedge clk);
    #1;
    chk("switch_now", 7, phy);
    wait_ev(1);
    chk("switch_code", beacon_service_pkg::OUT_SUCCESS, scode);
    go(2, 9, 2);
    #1;
    chk("notice_on", 1, elem);
    chk("countdown", 1, cdown);
    wait_ev(0);
    @(posedge clk);
    #1;
    chk("countdown", 0, cdown);
    chk("hold_channel", 7, phy);
    wait_ev(0);
    @(posedge clk);
    #1;
    chk("late_channel", 9, phy);
    chk("notice_off", 0, elem);
    wait_ev(1);
    chk("late_code", beacon_service_pkg::OUT_SUCCESS, scode);
    rx_on <= 1'b0;
    go(2, 3, 0);
    wait_ev(1);
    chk("switch_fail", beacon_service_pkg::OUT_FAILURE, scode);
    chk("all_frames", 3, phy);
    go(1, 0, 0);
    #1;
    chk("stop_enable", 0, ben);
    wait_ev(2);
    chk("stop_code", beacon_service_pkg::OUT_SUCCESS, ecode);
    bus(0, beacon_service_pkg::STATUS_OFF, 0);
    chk("status", 32'h0000_0030, rdata);
    conclude();
  end
endmodule
